// ===== ifsc_defs.svh
// Register offsets, field positions, reset values and widths of the
// FIFO-status and slot interrupt controller.
// Assumes inclusion by bare name from the package and the top module.
`ifndef IFSC_DEFS_SVH
`define IFSC_DEFS_SVH

// ============================================================
// Register indices (16-bit registers, word addressed)
`define IFSC_ADDR_W             8
`define IFSC_OFS_STATUS         8'h00
`define IFSC_OFS_MASK           8'h01
`define IFSC_OFS_PINCTL         8'h02
`define IFSC_OFS_THRESH         8'h06

// ============================================================
// Field positions
`define IFSC_STAT_CNT_HI        15
`define IFSC_STAT_CNT_LO        8
`define IFSC_STAT_FLUSH_BIT     15
`define IFSC_STAT_SLOTB_BIT     6
`define IFSC_STAT_SLOTA_BIT     5
`define IFSC_MASK_FIFO_BIT      8
`define IFSC_MASK_SLOTB_BIT     6
`define IFSC_MASK_SLOTA_BIT     5
`define IFSC_PIN_ENA_BIT        2
`define IFSC_PIN_DRV_BIT        1
`define IFSC_PIN_POL_BIT        0
`define IFSC_THR_HI             13
`define IFSC_THR_LO             8

// ============================================================
// Reset values and write masks
`define IFSC_MASK_RST           16'h00FF
`define IFSC_PINCTL_RST         16'h0000
`define IFSC_THRESH_RST         16'h0000
`define IFSC_MASK_WMASK         16'hFFFF
`define IFSC_PINCTL_WMASK       16'h0007
`define IFSC_THRESH_WMASK       16'h3FFF

`endif

// ===== ifsc_pkg.sv
// Types of the FIFO-status and slot interrupt controller.
// Assumes ifsc_defs.svh is on the include path.
`include "ifsc_defs.svh"

package ifsc_pkg;

   // ============================================================
   // Whole state of the controller, registered in one place
   typedef struct packed {
      logic        slota_flag;
      logic        slotb_flag;
      logic [15:0] mask;
      logic [15:0] pinctl;
      logic [15:0] thresh;
      logic        irq;
      logic        flush;
      logic        pin_level;
      logic        pin_oe;
      logic [15:0] rdata;
      logic        rvalid;
   } ifsc_state_t;

endpackage

// ===== ifsc_top.sv
// FIFO-level reporting, slot event flags, interrupt masking and the
// configurable interrupt pin driver.
// Assumes a register port from the serial interface engine, synchronous
// to clk_i, with single-cycle write and read strobes, and pulse inputs
// from the sample sequencer for each slot event.
//
// Summary of operation
// [R01] Status upper byte shows bytes currently waiting in the data FIFO.
// [R02] Byte count halved to words before comparing with word threshold.
// [R03] Writing one to status bit 15 flushes FIFO when access is enabled.
// [R04] Slot B event sets status bit 6; writing one clears it.
// [R05] Slot A event sets status bit 5; writing one clears it.
// [R06] Writing zero to a slot event flag leaves it unchanged.
// [R07] Mask bit 8 gates the FIFO threshold interrupt, zero enables, reset zero.
// [R08] Mask bit 6 gates slot B interrupt, zero enables, reset masked.
// [R09] Mask bit 5 gates slot A interrupt, zero enables, reset masked.
// [R10] Pin output enable bit clear floats the pin; flags keep updating.
// [R11] Drive style zero always drives; one drives only while asserted.
// [R12] Polarity bit zero gives active high pin, one active low.
// [R13] FIFO interrupt raised while FIFO word count exceeds six-bit threshold.
// [R14] FIFO interrupt drops by itself once count no longer exceeds threshold.
// [R15] Shared pins use drive-when-asserted style with a matching board pull.
// [R16] Interrupt is OR of unmasked active flags and FIFO condition.
`timescale 1ns/1ps
`include "ifsc_defs.svh"

module ifsc_top #(
   parameter int ADDR_W = `IFSC_ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [15:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output      logic [15:0]       reg_rdata_o,
   output      logic              reg_rvalid_o,
   input  wire logic [7:0]        fifo_bytes_i,
   input  wire logic              fifo_host_access_enable_i,
   input  wire logic              slota_event_i,
   input  wire logic              slotb_event_i,
   output      logic              fifo_flush_o,
   output      logic              irq_pending_o,
   output      logic              irq_pin_o,
   output      logic              irq_pin_oe_o
);

   // ============================================================
   // Helper functions

   // Register index match, shared by the write and read decoders
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        ofs);
      addr_is = (a == ADDR_W'(ofs));
   endfunction

   // Masked register update: only writable bits take new data
   function automatic logic [15:0] wr_field(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] wmask);
      wr_field = (old_v & ~wmask) | (new_v & wmask);
   endfunction

   // ============================================================
   // State

   ifsc_pkg::ifsc_state_t st;
   ifsc_pkg::ifsc_state_t next_st;

   logic        wr_status;
   logic        wr_mask;
   logic        wr_pinctl;
   logic        wr_thresh;
   logic [6:0]  fifo_words;
   logic [5:0]  thresh_words;
   logic        fifo_over;
   logic        irq_raw;
   logic [15:0] status_view;
   logic [15:0] rd_mux;

   // ============================================================
   // Write decode

   always_comb begin
      wr_status = reg_wr_i && addr_is(reg_addr_i, `IFSC_OFS_STATUS);
      wr_mask   = reg_wr_i && addr_is(reg_addr_i, `IFSC_OFS_MASK);
      wr_pinctl = reg_wr_i && addr_is(reg_addr_i, `IFSC_OFS_PINCTL);
      wr_thresh = reg_wr_i && addr_is(reg_addr_i, `IFSC_OFS_THRESH);
   end

   // ============================================================
   // FIFO threshold compare

   always_comb begin
      // [R02] bytes to words
      // An odd trailing byte is not a whole word, so it is dropped.
      fifo_words   = fifo_bytes_i[7:1];
      thresh_words = st.thresh[`IFSC_THR_HI:`IFSC_THR_LO];
      // [R13] words exceed threshold
      // [R14] Self clearing compare
      // Level compare with no latch: falls as soon as the word count drops to the threshold.
      fifo_over    = fifo_words > {1'b0, thresh_words};
   end

   // ============================================================
   // Interrupt combine

   always_comb begin
      // [R16] OR of unmasked sources
      irq_raw = 1'b0;
      // [R09] slot A gate
      if (st.slota_flag && !st.mask[`IFSC_MASK_SLOTA_BIT]) begin
         irq_raw = 1'b1;
      end
      // [R08] slot B gate
      if (st.slotb_flag && !st.mask[`IFSC_MASK_SLOTB_BIT]) begin
         irq_raw = 1'b1;
      end
      // [R07] FIFO gate
      if (fifo_over && !st.mask[`IFSC_MASK_FIFO_BIT]) begin
         irq_raw = 1'b1;
      end
   end

   // ============================================================
   // Read view

   always_comb begin
      status_view = 16'h0000;
      // [R01] FIFO byte count
      status_view[`IFSC_STAT_CNT_HI:`IFSC_STAT_CNT_LO] = fifo_bytes_i;
      status_view[`IFSC_STAT_SLOTB_BIT] = st.slotb_flag;
      status_view[`IFSC_STAT_SLOTA_BIT] = st.slota_flag;

      rd_mux = 16'h0000;
      if (addr_is(reg_addr_i, `IFSC_OFS_STATUS)) begin
         rd_mux = status_view;
      end else if (addr_is(reg_addr_i, `IFSC_OFS_MASK)) begin
         rd_mux = st.mask;
      end else if (addr_is(reg_addr_i, `IFSC_OFS_PINCTL)) begin
         rd_mux = st.pinctl;
      end else if (addr_is(reg_addr_i, `IFSC_OFS_THRESH)) begin
         rd_mux = st.thresh;
      end
   end

   // ============================================================
   // Next state

   always_comb begin
      next_st = st;

      // [R05] slot A flag, W1C
      // [R06] zero write holds
      // Set is applied after the clear so a same-cycle event is kept.
      if (wr_status && reg_wdata_i[`IFSC_STAT_SLOTA_BIT]) begin
         next_st.slota_flag = 1'b0;
      end
      if (slota_event_i) begin
         next_st.slota_flag = 1'b1;
      end

      // [R04] slot B flag, W1C
      if (wr_status && reg_wdata_i[`IFSC_STAT_SLOTB_BIT]) begin
         next_st.slotb_flag = 1'b0;
      end
      if (slotb_event_i) begin
         next_st.slotb_flag = 1'b1;
      end

      // [R03] FIFO flush strobe
      // Without access enabled the write to bit 15 is silently dropped.
      next_st.flush = wr_status && fifo_host_access_enable_i
                      && reg_wdata_i[`IFSC_STAT_FLUSH_BIT];

      if (wr_mask) begin
         next_st.mask = wr_field(st.mask, reg_wdata_i, `IFSC_MASK_WMASK);
      end
      if (wr_pinctl) begin
         next_st.pinctl = wr_field(st.pinctl, reg_wdata_i,
                                   `IFSC_PINCTL_WMASK);
      end
      if (wr_thresh) begin
         next_st.thresh = wr_field(st.thresh, reg_wdata_i,
                                   `IFSC_THRESH_WMASK);
      end

      next_st.irq = irq_raw;

      // [R12] polarity select
      next_st.pin_level = irq_raw ^ st.pinctl[`IFSC_PIN_POL_BIT];

      // [R10] pin enable
      // [R11] drive style
      // Open-drain style releases the pin when idle; the board pull
      // must sit at the idle level, which a shared pin also needs.
      next_st.pin_oe = st.pinctl[`IFSC_PIN_ENA_BIT]
                       && (!st.pinctl[`IFSC_PIN_DRV_BIT] || irq_raw);

      next_st.rvalid = reg_rd_i;
      if (reg_rd_i) begin
         next_st.rdata = rd_mux;
      end
   end

   // ============================================================
   // State register

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st.slota_flag <= 1'b0;
         st.slotb_flag <= 1'b0;
         st.mask       <= `IFSC_MASK_RST;
         st.pinctl     <= `IFSC_PINCTL_RST;
         st.thresh     <= `IFSC_THRESH_RST;
         st.irq        <= 1'b0;
         st.flush      <= 1'b0;
         st.pin_level  <= 1'b0;
         st.pin_oe     <= 1'b0;
         st.rdata      <= 16'h0000;
         st.rvalid     <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ============================================================
   // Outputs

   always_comb begin
      reg_rdata_o   = st.rdata;
      reg_rvalid_o  = st.rvalid;
      fifo_flush_o  = st.flush;
      irq_pending_o = st.irq;
      irq_pin_o     = st.pin_level;
      irq_pin_oe_o  = st.pin_oe;
   end

endmodule

// ===== ifsc_host_model.sv
// Host view of the shared interrupt line with its board pull resistor.
// Assumes the pull is fitted to suit the programmed polarity.
`timescale 1ns/1ps
module ifsc_host_model (
   input  wire logic pin_i,
   input  wire logic oe_i,
   input  wire logic pol_i,
   output      logic line_o,
   output      logic seen_o
);
   // pull matches polarity
   // A released line rests at the inactive level, never at a stale value
   assign line_o = oe_i ? pin_i : pol_i;
   assign seen_o = line_o ^ pol_i;
endmodule

// ===== ifsc_chk.sv
// Port checker of the interrupt controller.
// Assumes it is bound into ifsc_top; keeps shadows of written registers.
`timescale 1ns/1ps
module ifsc_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [15:0]       reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic              reg_rvalid_o,
   input wire logic [7:0]        fifo_bytes_i,
   input wire logic              fifo_host_access_enable_i,
   input wire logic              slota_event_i,
   input wire logic              slotb_event_i,
   input wire logic              fifo_flush_o,
   input wire logic              irq_pending_o,
   input wire logic              irq_pin_o,
   input wire logic              irq_pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [15:0] mk;
   logic [2:0]  pc;
   logic [5:0]  th;
   logic        fl;
   logic        ovr;
   assign fl = reg_wr_i && reg_addr_i == ADDR_W'(0) && reg_wdata_i[15]
               && fifo_host_access_enable_i;
   assign ovr = fifo_bytes_i[7:1] > {1'h0, th};
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mk <= 16'h00ff;
         pc <= 3'h0;
         th <= 6'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_W'(1)) mk <= reg_wdata_i;
         if (reg_addr_i == ADDR_W'(2)) pc <= reg_wdata_i[2:0];
         if (reg_addr_i == ADDR_W'(6)) th <= reg_wdata_i[13:8];
      end
   end
   // ============================================================
   // Register port and flush
   a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   a_flush_cause: assert property ($past(rst_n_i) |->
      fifo_flush_o == $past(fl)) else $error("flush pulse wrong");
   // ============================================================
   // Interrupt sources
   a_slota_irq: assert property (slota_event_i && !mk[5] && !reg_wr_i
      |=> ##1 irq_pending_o) else $error("slot A irq missing");
   a_slotb_irq: assert property (slotb_event_i && !mk[6] && !reg_wr_i
      |=> ##1 irq_pending_o) else $error("slot B irq missing");
   a_fifo_irq: assert property (ovr && !mk[8] |=> irq_pending_o)
      else $error("fifo irq missing");
   a_irq_quiet: assert property (mk[5] && mk[6] && (mk[8] || !ovr)
      |=> !irq_pending_o) else $error("irq without cause");
   // ============================================================
   // Pin driver
   a_pin_level: assert property ($past(rst_n_i) |->
      irq_pin_o == (irq_pending_o ^ $past(pc[0])))
      else $error("pin level wrong");
   a_pin_drive: assert property ($past(rst_n_i) |-> irq_pin_oe_o ==
      ($past(pc[2]) & (~$past(pc[1]) | irq_pending_o)))
      else $error("pin enable wrong");
endmodule
bind ifsc_top ifsc_chk #(.ADDR_W(ADDR_W)) u_ifsc_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rvalid_o(reg_rvalid_o), .fifo_bytes_i(fifo_bytes_i),
   .fifo_host_access_enable_i(fifo_host_access_enable_i),
   .slota_event_i(slota_event_i), .slotb_event_i(slotb_event_i),
   .fifo_flush_o(fifo_flush_o), .irq_pending_o(irq_pending_o),
   .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

// ===== tb_top.sv
// Self-checking bench of the interrupt controller, random plus corners.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin \
   fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
   logic        clk_i, rst_n_i, wr, rd, en, ea, eb, x;
   logic        rvalid, flush, irq, pin, oe, line, seen;
   logic [7:0]  addr, fb;
   logic [15:0] wd, rdata;
   logic [31:0] seed = 32'hdee9_ac60;
   logic [31:0] r;
   logic [5:0]  th;
   logic [2:0]  pc;
   int          fail_count, n_tests, i, k;
   ifsc_top u_ifsc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .fifo_bytes_i(fb),
      .fifo_host_access_enable_i(en), .slota_event_i(ea),
      .slotb_event_i(eb), .fifo_flush_o(flush), .irq_pending_o(irq),
      .irq_pin_o(pin), .irq_pin_oe_o(oe));
   ifsc_host_model u_ifsc_host_model (.pin_i(pin), .oe_i(oe),
      .pol_i(pc[0]), .line_o(line), .seen_o(seen));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Odd byte counts round down to whole words
   function automatic logic exp_irq(logic [7:0] b, logic [5:0] t, logic m);
      return (b[7:1] > {1'h0, t}) & ~m;
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_i);
      wr = 1'h1; addr = a; wd = d;
      @(negedge clk_i);
      wr = 1'h0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_i);
      rd = 1'h1; addr = a;
      @(negedge clk_i);
      rd = 1'h0;
      `CHK("rvalid", 1'h1, rvalid)
      `CHK("rdata", e, rdata)
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      #2_000_000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {rst_n_i, wr, rd, en, ea, eb} = 6'h00;
      addr = 8'h00; wd = 16'h0000; fb = 8'h00; pc = 3'h0;
      fail_count = 0; n_tests = 0;
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'h1;
      rd_chk(8'h01, 16'h00ff);
      rd_chk(8'h02, 16'h0000);
      rd_chk(8'h06, 16'h0000);
      rd_chk(8'h03, 16'h0000);
      // ============================================================
      // Slot flags, with the pin disabled so flags must still update
      for (k = 5; k < 7; k++) begin
         r = rnd();
         wr_reg(8'h01, 16'h00ff ^ (16'(r[0]) << k));
         @(negedge clk_i);
         ea = (k == 5); eb = (k == 6);
         @(negedge clk_i);
         ea = 1'h0; eb = 1'h0;
         @(negedge clk_i);
         `CHK("irq", r[0], irq)
         wr_reg(8'h00, 16'h7f9f);
         rd_chk(8'h00, 16'h0001 << k);
         wr_reg(8'h00, 16'h0001 << k);
         rd_chk(8'h00, 16'h0000);
      end
      for (k = 0; k < 2; k++) begin
         en = k[0];
         wr_reg(8'h00, 16'h8000);
         `CHK("flush", k[0], flush)
      end
      en = 1'h0;
      // ============================================================
      // Threshold, mask and every pin mode; first two are threshold corners
      for (i = 0; i < 24; i++) begin
         r = rnd();
         th = (i < 2) ? 6'(i * 63) : r[5:0];
         pc = i[2:0];
         fb = i[0] ? {1'h0, th, r[6]} : r[15:8];
         wr_reg(8'h06, {2'h0, th, r[23:16]});
         wr_reg(8'h02, {13'h0000, pc});
         wr_reg(8'h01, {7'h00, r[24], 8'h00});
         repeat (2) @(negedge clk_i);
         x = exp_irq(fb, th, r[24]);
         `CHK("irq", x, irq)
         `CHK("oe", pc[2] & (~pc[1] | x), oe)
         `CHK("pin", x ^ pc[0], pin)
         `CHK("seen", pc[2] & x, seen)
      end
      rd_chk(8'h00, {fb, 8'h00});
      rd_chk(8'h06, {2'h0, th, r[23:16]});
      give_verdict();
   end
endmodule
